// [core/mvl_pkg.sv]
// Constants and types of the meter value conditioning and event log block
// Assumes one system clock and a synchronous active-low reset
// Behaviour
// - A current sample at or below the floor is replaced by zero for display, power and comms.
// - After reset the current floor holds fifty amperes.
// - A floor of zero turns zeroing off and passes every current unchanged.
// - A direction bit selects top-down or bottom-up as normal; power is positive in it, negative otherwise.
// - Current magnitudes are always reported as positive values.
// - Energy accumulates in two unsigned counters, one per direction.
// - Every non-trip event is logged with a time stamp and an incoming or outgoing flag.
// - The event log keeps the last ten events, the oldest dropped when a new one arrives on a full log.
// - The trip log keeps the last five trips with a time stamp and code but no incoming flag, the oldest dropped when full.
// - Both logs exist only when the communication module is fitted.
package mvl_pkg;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int          CUR_W       = 16;
  localparam int          VOLT_W      = 16;
  localparam int          PWR_W       = 34;
  localparam int          NRG_W       = 48;
  localparam int          TS_W        = 32;
  localparam int          EVT_W       = 16;
  localparam int          EVT_DEPTH   = 10;
  localparam int          TRIP_DEPTH  = 5;
  localparam logic [15:0] FLOOR_RST   = 16'h0032;
  localparam logic        DIR_RST     = 1'b0;
  localparam logic        DIR_TOPDOWN = 1'b0;

endpackage : mvl_pkg

// [core/mvl_log_mem.sv]
// Small circular log memory holding the newest entries
// Assumes write and read requests arrive on the same clock
`timescale 1ns/100ps
module mvl_log_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     wr_en,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data,
  output logic      [$clog2(DEPTH):0]   count
);

  // ****************************************
  // Storage and pointers
  // ****************************************
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wp_q, wp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic [WIDTH-1:0] rd_q, rd_d;
  logic [AW-1:0]    slot;

  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    cnt_d = cnt_q;
    // Newest entry at index 0; wrap overwrites the oldest
    slot  = (wp_q > rd_idx) ? AW'(wp_q - rd_idx - 1'b1) : AW'(LAST - rd_idx + wp_q);
    // Index past the count reads zero, also on a full log
    rd_d  = ((AW+1)'(rd_idx) < cnt_q) ? mem_q[slot] : '0;
    if (wr_en) begin
      mem_d[wp_q] = wr_data;
      wp_d        = (wp_q == LAST) ? '0 : AW'(wp_q + 1'b1);
      if (cnt_q != FULL) begin
        cnt_d = (AW+1)'(cnt_q + 1'b1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q  <= '0;
      cnt_q <= '0;
      rd_q  <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      cnt_q <= cnt_d;
      rd_q  <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign count   = cnt_q;

endmodule : mvl_log_mem

// [core/mvl_phase.sv]
// One phase: floors current and forms signed active power
// Assumes samples are valid in the cycle of sample_valid
`timescale 1ns/100ps
module mvl_phase (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              sample_valid,
  input  wire logic [mvl_pkg::CUR_W-1:0]         cur_raw,
  input  wire logic [mvl_pkg::VOLT_W-1:0]        volt,
  input  wire logic                              flow_topdown,
  input  wire logic [mvl_pkg::CUR_W-1:0]         cur_floor,
  output logic      [mvl_pkg::CUR_W-1:0]         cur_out,
  output logic signed [mvl_pkg::PWR_W-1:0]       pwr_out
);

  // ****************************************
  // Floor and power
  // ****************************************
  logic [mvl_pkg::CUR_W-1:0]         cur_q, cur_d, cur_f;
  logic signed [mvl_pkg::PWR_W-1:0]  pwr_q, pwr_d;
  logic [mvl_pkg::PWR_W-2:0]         mag;
  logic [mvl_pkg::CUR_W+mvl_pkg::VOLT_W-1:0] prod;

  always_comb begin
    // Floor zero disables zeroing; magnitude is unsigned so always positive
    cur_f = (cur_floor != '0 && cur_raw <= cur_floor) ? '0 : cur_raw;
    // Product formed at full width so no high bits are lost
    prod  = cur_f * volt;
    mag   = (mvl_pkg::PWR_W-1)'(prod);
    cur_d = cur_q;
    pwr_d = pwr_q;
    if (sample_valid) begin
      cur_d = cur_f;
      // Normal direction gives positive sign
      pwr_d = (flow_topdown == mvl_pkg::DIR_TOPDOWN) ? $signed({1'b0, mag})
                                                     : -$signed({1'b0, mag});
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_q <= '0;
      pwr_q <= '0;
    end else begin
      cur_q <= cur_d;
      pwr_q <= pwr_d;
    end
  end

  assign cur_out = cur_q;
  assign pwr_out = pwr_q;

endmodule : mvl_phase

// [core/mvl_top.sv]
// Top of the meter value conditioning and event log block
// Assumes samples, events and configuration come from logic on clk
`timescale 1ns/100ps
module mvl_top (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              comm_fitted,
  input  wire logic                              cfg_floor_we,
  input  wire logic [mvl_pkg::CUR_W-1:0]         cfg_floor,
  input  wire logic                              cfg_dir_we,
  input  wire logic                              cfg_dir_reverse,
  input  wire logic                              sample_valid,
  input  wire logic [3*mvl_pkg::CUR_W-1:0]       cur_raw,
  input  wire logic [3*mvl_pkg::VOLT_W-1:0]      volt,
  input  wire logic [mvl_pkg::TS_W-1:0]          time_now,
  input  wire logic                              evt_valid,
  input  wire logic                              evt_is_trip,
  input  wire logic                              evt_incoming,
  input  wire logic [mvl_pkg::EVT_W-1:0]         evt_code,
  input  wire logic [3:0]                        evt_rd_idx,
  input  wire logic [2:0]                        trip_rd_idx,
  output logic      [mvl_pkg::CUR_W-1:0]         floor_out,
  output logic                                   dir_out,
  output logic      [3*mvl_pkg::CUR_W-1:0]       cur_out,
  output logic signed [mvl_pkg::PWR_W+1:0]       pwr_total,
  output logic      [mvl_pkg::NRG_W-1:0]         nrg_normal,
  output logic      [mvl_pkg::NRG_W-1:0]         nrg_reverse,
  output logic      [mvl_pkg::TS_W+mvl_pkg::EVT_W:0] evt_rd_data,
  output logic      [4:0]                        evt_count,
  output logic      [mvl_pkg::TS_W+mvl_pkg::EVT_W-1:0] trip_rd_data,
  output logic      [3:0]                        trip_count
);

  // ****************************************
  // Configuration
  // ****************************************
  localparam int PW = mvl_pkg::PWR_W;
  localparam int EW = mvl_pkg::TS_W + mvl_pkg::EVT_W + 1;
  localparam int TW = mvl_pkg::TS_W + mvl_pkg::EVT_W;

  logic [mvl_pkg::CUR_W-1:0] floor_q, floor_d;
  logic                      dir_q, dir_d;

  always_comb begin
    floor_d = cfg_floor_we ? cfg_floor : floor_q;
    dir_d   = cfg_dir_we ? cfg_dir_reverse : dir_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      floor_q <= mvl_pkg::FLOOR_RST;
      dir_q   <= mvl_pkg::DIR_RST;
    end else begin
      floor_q <= floor_d;
      dir_q   <= dir_d;
    end
  end

  // ****************************************
  // Phases
  // ****************************************
  logic [3*mvl_pkg::CUR_W-1:0] cur_ph;
  logic signed [PW-1:0]        pwr_ph [3];
  logic                        pwr_stb_q;

  for (genvar g = 0; g < 3; g++) begin : g_ph
    mvl_phase u_ph (
      .clk          (clk),
      .rst_n        (rst_n),
      .sample_valid (sample_valid),
      .cur_raw      (cur_raw[g*mvl_pkg::CUR_W +: mvl_pkg::CUR_W]),
      .volt         (volt[g*mvl_pkg::VOLT_W +: mvl_pkg::VOLT_W]),
      .flow_topdown (dir_q),
      .cur_floor    (floor_q),
      .cur_out      (cur_ph[g*mvl_pkg::CUR_W +: mvl_pkg::CUR_W]),
      .pwr_out      (pwr_ph[g])
    );
  end

  // ****************************************
  // Total power and energy
  // ****************************************
  logic signed [PW+1:0]      tot_q, tot_d;
  logic [3*mvl_pkg::CUR_W-1:0] curo_q, curo_d;
  logic [mvl_pkg::NRG_W-1:0] nn_q, nn_d, nr_q, nr_d;
  logic                      stb_d;

  always_comb begin
    stb_d  = sample_valid;
    curo_d = cur_ph;
    tot_d  = $signed({{2{pwr_ph[0][PW-1]}}, pwr_ph[0]})
           + $signed({{2{pwr_ph[1][PW-1]}}, pwr_ph[1]})
           + $signed({{2{pwr_ph[2][PW-1]}}, pwr_ph[2]});
    if (!pwr_stb_q) begin
      tot_d = tot_q;
    end
    // Energy sums magnitude per sample; wraps silently at counter width
    nn_d = nn_q;
    nr_d = nr_q;
    if (pwr_stb_q) begin
      if (tot_d[PW+1]) begin
        nr_d = mvl_pkg::NRG_W'(nr_q + (PW+2)'(-tot_d));
      end else begin
        nn_d = mvl_pkg::NRG_W'(nn_q + tot_d);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_stb_q <= 1'b0;
      tot_q     <= '0;
      curo_q    <= '0;
      nn_q      <= '0;
      nr_q      <= '0;
    end else begin
      pwr_stb_q <= stb_d;
      tot_q     <= tot_d;
      curo_q    <= curo_d;
      nn_q      <= nn_d;
      nr_q      <= nr_d;
    end
  end

  // ****************************************
  // Event and trip logs
  // ****************************************
  logic          evt_we, trip_we;
  logic [EW-1:0] evt_word;
  logic [TW-1:0] trip_word;
  logic [EW-1:0] evt_mem_rd;
  logic [TW-1:0] trip_mem_rd;
  logic [4:0]    evt_mem_cnt;
  logic [3:0]    trip_mem_cnt;
  logic [EW-1:0] erd_q, erd_d;
  logic [TW-1:0] trd_q, trd_d;
  logic [4:0]    ecnt_q, ecnt_d;
  logic [3:0]    tcnt_q, tcnt_d;

  always_comb begin
    // Without the comm module nothing is stored or shown
    evt_we    = evt_valid && !evt_is_trip && comm_fitted;
    trip_we   = evt_valid && evt_is_trip && comm_fitted;
    evt_word  = {time_now, evt_incoming, evt_code};
    trip_word = {time_now, evt_code};
    erd_d     = comm_fitted ? evt_mem_rd : '0;
    trd_d     = comm_fitted ? trip_mem_rd : '0;
    ecnt_d    = comm_fitted ? evt_mem_cnt : '0;
    tcnt_d    = comm_fitted ? trip_mem_cnt : '0;
  end

  mvl_log_mem #(
    .WIDTH (EW),
    .DEPTH (mvl_pkg::EVT_DEPTH)
  ) u_evt (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (evt_we),
    .wr_data (evt_word),
    .rd_idx  (evt_rd_idx),
    .rd_data (evt_mem_rd),
    .count   (evt_mem_cnt)
  );

  mvl_log_mem #(
    .WIDTH (TW),
    .DEPTH (mvl_pkg::TRIP_DEPTH)
  ) u_trip (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (trip_we),
    .wr_data (trip_word),
    .rd_idx  (trip_rd_idx),
    .rd_data (trip_mem_rd),
    .count   (trip_mem_cnt)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erd_q  <= '0;
      trd_q  <= '0;
      ecnt_q <= '0;
      tcnt_q <= '0;
    end else begin
      erd_q  <= erd_d;
      trd_q  <= trd_d;
      ecnt_q <= ecnt_d;
      tcnt_q <= tcnt_d;
    end
  end

  assign floor_out    = floor_q;
  assign dir_out      = dir_q;
  assign cur_out      = curo_q;
  assign pwr_total    = tot_q;
  assign nrg_normal   = nn_q;
  assign nrg_reverse  = nr_q;
  assign evt_rd_data  = erd_q;
  assign evt_count    = ecnt_q;
  assign trip_rd_data = trd_q;
  assign trip_count   = tcnt_q;

endmodule : mvl_top

// [verification/mvl_top_asserts.sv]
// Port checker for mvl_top
// Assumes a bind onto mvl_top, one clock, sync reset
`timescale 1ns/100ps
module mvl_chk (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               comm_fitted,
  input wire logic               sample_valid,
  input wire logic [47:0]        cur_raw,
  input wire logic [31:0]        time_now,
  input wire logic               evt_valid,
  input wire logic               evt_is_trip,
  input wire logic               evt_incoming,
  input wire logic [15:0]        evt_code,
  input wire logic [3:0]         evt_rd_idx,
  input wire logic [15:0]        floor_out,
  input wire logic               dir_out,
  input wire logic [47:0]        cur_out,
  input wire logic signed [35:0] pwr_total,
  input wire logic [47:0]        nrg_normal,
  input wire logic [47:0]        nrg_reverse,
  input wire logic [48:0]        evt_rd_data,
  input wire logic [4:0]         evt_count,
  input wire logic [47:0]        trip_rd_data
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire lo = cur_raw[15:0] <= floor_out && cur_raw[31:16] <= floor_out
            && cur_raw[47:32] <= floor_out;
  AST_RST_CFG: assert property ($rose(rst_n) |-> floor_out == mvl_pkg::FLOOR_RST
    && dir_out == mvl_pkg::DIR_RST) else $error("floor or direction wrong after reset");
  AST_FLOOR: assert property (sample_valid && floor_out != 16'h0000 &&
    cur_raw[15:0] <= floor_out |-> ##2 cur_out[15:0] == 16'h0000)
    else $error("current at floor not zeroed");
  AST_PASS: assert property (sample_valid && floor_out == 16'h0000
    |-> ##2 cur_out == $past(cur_raw, 2)) else $error("current not passed through");
  AST_NO_PWR: assert property (sample_valid && lo && floor_out != 16'h0000
    |-> ##2 pwr_total == 36'sh0) else $error("floored currents gave power");
  AST_NRG: assert property (sample_valid ##2 1'b1 |-> (pwr_total < 0) ?
    (nrg_reverse == $past(nrg_reverse) - 48'(pwr_total) && $stable(nrg_normal)) :
    (nrg_normal == $past(nrg_normal) + 48'(pwr_total) && $stable(nrg_reverse)))
    else $error("energy counter step wrong");
  AST_EVT_MAX: assert property (evt_count <= 5'h0a) else $error("event count over ten");
  AST_EVT_DATA: assert property (evt_valid && comm_fitted && !evt_is_trip &&
    evt_rd_idx == 4'h0 ##1 evt_rd_idx == 4'h0 ##1 comm_fitted |-> ##1
    evt_rd_data == {$past(time_now, 3), $past(evt_incoming, 3), $past(evt_code, 3)})
    else $error("event entry wrong");
  AST_NO_LOG: assert property (!comm_fitted [*3] |-> evt_rd_data == 49'h0
    && trip_rd_data == 48'h0) else $error("log visible without comm module");
endmodule : mvl_chk

// [verification/mvl_bus_src.sv]
// Internal bus event source feeding the block
// Assumes calls at the falling clock edge
`timescale 1ns/100ps
module mvl_bus_src (
  input  wire logic        clk,
  output logic             evt_valid,
  output logic             evt_is_trip,
  output logic             evt_incoming,
  output logic [15:0]      evt_code
);
  initial begin
    evt_valid = 1'b0;
    evt_is_trip = 1'b0;
    evt_incoming = 1'b0;
    evt_code = 16'h0000;
  end
  // Held one cycle, valid stays up for back-to-back events
  task send(input logic t, input logic i, input logic [15:0] k);
    evt_is_trip = t;
    evt_incoming = i;
    evt_code = k;
    evt_valid = 1'b1;
    @(negedge clk);
  endtask : send
  // Incoming and code lines flip while idle so stale values never match
  task stop();
    evt_valid = 1'b0;
    evt_incoming = ~evt_incoming;
    evt_code = ~evt_code;
  endtask : stop
endmodule : mvl_bus_src

// [verification/testbench.sv]
// Self-checking bench for mvl_top
// Assumes the bus source model and checker files
`timescale 1ns/100ps
module testbench;
  logic        clk, rst_n, comm_fitted, cfg_floor_we, cfg_dir_we, cfg_dir_reverse;
  logic        sample_valid, evt_valid, evt_is_trip, evt_incoming, dir_out;
  logic [15:0] cfg_floor, evt_code, floor_out;
  logic [47:0] cur_raw, volt, cur_out, nrg_normal, nrg_reverse, trip_rd_data;
  logic [31:0] time_now;
  logic [3:0]  evt_rd_idx, trip_count;
  logic [2:0]  trip_rd_idx;
  logic [4:0]  evt_count;
  logic [48:0] evt_rd_data;
  logic signed [35:0] pwr_total;
  logic [48:0] eq[$];
  logic [47:0] tq[$];
  int          err_count, samples_checked, seed, cyc;
  longint      e_nrm, e_rev;
  mvl_top dut (.*);
  mvl_bus_src src (.clk, .evt_valid, .evt_is_trip, .evt_incoming, .evt_code);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  function automatic logic [15:0] eflr(logic [15:0] c, logic [15:0] f);
    return (f != 16'h0000 && c <= f) ? 16'h0000 : c;
  endfunction : eflr
  function automatic longint epwr(logic [47:0] c, logic [47:0] v, logic d);
    longint s;
    s = 0;
    for (int g = 0; g < 3; g++) s += longint'(c[g*16+:16]) * longint'(v[g*16+:16]);
    return d ? -s : s;
  endfunction : epwr
  task automatic cfg(input logic [15:0] f, input logic d);
    cfg_floor = f;
    cfg_dir_reverse = d;
    cfg_floor_we = 1'b1;
    cfg_dir_we = 1'b1;
    @(negedge clk);
    cfg_floor_we = 1'b0;
    cfg_dir_we = 1'b0;
    @(negedge clk);
    chk(floor_out, f, "floor");
    chk(dir_out, d, "direction");
  endtask : cfg
  // Phase 0 sits on the floor boundary; lo masks every phase to 31 or less, under the 50 and 500 floors
  task automatic smp(input logic [15:0] f, input logic d, input logic lo);
    logic [47:0] c, e;
    longint      p;
    c = 48'({$random(seed), $random(seed)});
    c[15:0] = f + 16'($unsigned($random(seed)) % 3) - 16'h0001;
    if (lo) c = c & {3{16'h001f}};
    cur_raw = c;
    volt = 48'({$random(seed), $random(seed)});
    sample_valid = 1'b1;
    for (int g = 0; g < 3; g++) e[g*16+:16] = eflr(c[g*16+:16], f);
    p = epwr(e, volt, d);
    if (p < 0) e_rev -= p;
    else e_nrm += p;
    @(negedge clk);
    sample_valid = 1'b0;
    repeat (2) @(negedge clk);
    chk(cur_out, e, "current");
    chk(pwr_total, p, "power");
    chk(nrg_normal, e_nrm, "normal energy");
    chk(nrg_reverse, e_rev, "reverse energy");
  endtask : smp
  task automatic evt(input logic t);
    logic [48:0] r;
    r = 49'({$random(seed), $random(seed)});
    time_now = r[48:17];
    if (comm_fitted && t) tq.push_front({r[48:17], r[15:0]});
    if (comm_fitted && !t) eq.push_front(r);
    if (eq.size() > 10) eq.pop_back();
    if (tq.size() > 5) tq.pop_back();
    src.send(t, r[16], r[15:0]);
  endtask : evt
  // Log outputs read zero while the comm module is absent
  task automatic rd_chk();
    repeat (2) @(negedge clk);
    chk(evt_count, comm_fitted ? eq.size() : 0, "event count");
    chk(trip_count, comm_fitted ? tq.size() : 0, "trip count");
    // Indices past the count must read zero
    for (int i = 0; i < 16; i++) begin
      evt_rd_idx = 4'(i);
      trip_rd_idx = 3'(i % 8);
      repeat (2) @(negedge clk);
      chk(evt_rd_data, comm_fitted && i < eq.size() ? eq[i] : 0, "event entry");
      chk(trip_rd_data, comm_fitted && i % 8 < tq.size() ? tq[i % 8] : 0, "trip");
    end
    evt_rd_idx = 4'h0;
    trip_rd_idx = 3'h0;
    repeat (2) @(negedge clk);
  endtask : rd_chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    logic [15:0] fl [3];
    fl = '{16'h0032, 16'h0000, 16'h01f4};
    seed = 84636;
    {rst_n, cfg_floor_we, cfg_dir_we, cfg_dir_reverse, sample_valid} = 5'h00;
    {cfg_floor, cur_raw, volt, time_now, evt_rd_idx, trip_rd_idx} = 0;
    comm_fitted = 1'b1;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk(floor_out, mvl_pkg::FLOOR_RST, "floor reset");
    smp(16'h0032, 1'b0, 1'b0);
    for (int m = 0; m < 6; m++) begin
      cfg(fl[m / 2], m[0]);
      repeat (5) smp(fl[m / 2], m[0], 1'b0);
      smp(fl[m / 2], m[0], 1'b1);
    end
    $display("samples done");
    for (int i = 0; i < 30; i++) evt(i < 12 ? 1'b0 : i < 19 ? 1'b1 : 1'($random(seed)));
    src.stop();
    rd_chk();
    comm_fitted = 1'b0;
    repeat (3) evt(1'($random(seed)));
    src.stop();
    rd_chk();
    comm_fitted = 1'b1;
    rd_chk();
    $display("logs done");
    end_sim();
  end
endmodule : testbench
bind mvl_top mvl_chk u_chk (.*);
